/* File: rtl/ds3_sts1_stuffing_mapper.sv */
/*
 * DS3 into STS-1 payload envelope mapper with bit stuffing: elastic
 * store, envelope timer, row sequencer and stuffing decision.
 * Assumes DS3 bits arrive as same-clock strobes from upstream logic.
 */
`timescale 1ns/1ps

module ds3_sts1_stuffing_mapper
    import stuff_map_pkg::*;
#(
    parameter int FRAME_CYC = FRAME_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ds3_bit,
    input  wire logic       ds3_valid,
    output logic            spe_start,
    output logic [7:0]      spe_byte,
    output logic            spe_byte_valid,
    output logic [3:0]      opp_data_count,
    output logic            store_overrun,
    output logic            store_underrun
);

    ////////////////////////////////////////////////////////////////////////
    // Elastic store
    logic              mem [0:(1 << STORE_AW) - 1];
    logic [12:0]       wr_q;
    logic [12:0]       rd_q;
    logic [12:0]       rd_d;
    wire  [12:0]       fill = wr_q - rd_q;
    wire               store_full = (fill == STORE_DEPTH);
    wire               wr_en = ds3_valid && !store_full;

    always_ff @(posedge clk) begin
        if (wr_en)
            mem[wr_q[STORE_AW-1:0]] <= ds3_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // Envelope timer, independent of store state
    logic [12:0]       frame_cnt_q;
    wire               frame_tick = (frame_cnt_q == 13'(FRAME_CYC - 1));

    ////////////////////////////////////////////////////////////////////////
    // Position inside the envelope
    map_state_t        state_q;
    logic [9:0]        pos_q;
    logic [3:0]        row_q;
    logic [3:0]        nopp_q;
    logic [1:0]        phase_q;
    logic [5:0]        sh_q;

    // Stuffing decision from accumulated fill; a fixed band from FILL_LO to FILL_HI keeps nominal
    wire  [3:0]        nopp_d = (fill > FILL_HI) ? OPP_DATA_FAST :
                                (fill < FILL_LO) ? OPP_DATA_SLOW : OPP_DATA_NOM;

    wire               emit = (state_q == ST_EMIT);
    wire  [9:0]        pos1 = pos_q + 10'h001;
    wire  bit_type_t   t0 = bit_type(pos_q);
    wire  bit_type_t   t1 = bit_type(pos1);
    wire               opp_is_data = (row_q < nopp_q);
    wire               want0 = emit && ((t0 == BT_DATA) || (t0 == BT_OPP && opp_is_data));
    wire               want1 = emit && ((t1 == BT_DATA) || (t1 == BT_OPP && opp_is_data));
    wire  [1:0]        want_n = {1'b0, want0} + {1'b0, want1};
    // Never read past the write pointer; starve instead of repeating bits
    wire               starve = (fill < {11'h000, want_n});
    wire               take0 = want0 && !starve;
    wire               take1 = want1 && !starve;
    wire               m0 = mem[rd_q[STORE_AW-1:0]];
    wire               m1 = mem[STORE_AW'(rd_q + {12'h000, take0})];

    // Control bits all ones for a stuffed opportunity
    wire               b0 = (t0 == BT_CTL) ? !opp_is_data : take0 ? m0 : 1'b0;
    wire               b1 = (t1 == BT_CTL) ? !opp_is_data : take1 ? m1 : 1'b0;

    assign rd_d = rd_q + {12'h000, take0} + {12'h000, take1};

    wire               row_end = (pos_q == ROW_BITS - 10'h002);
    wire               spe_end = row_end && (row_q == ROWS - 4'h1);
    wire               byte_done = emit && (phase_q == 2'h3);
    wire  [9:0]        pos_d = row_end ? 10'h000 : pos_q + 10'h002;
    wire  [3:0]        row_d = row_end ? row_q + 4'h1 : row_q;
    wire  [12:0]       frame_cnt_d = frame_tick ? 13'h0000 : frame_cnt_q + 13'h0001;
    map_state_t        state_d;

    ////////////////////////////////////////////////////////////////////////
    // Envelope sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_WAIT: begin
                if (frame_tick)
                    state_d = ST_EMIT;
            end
            ST_EMIT: begin
                // A wrap always wins, so the envelope rate never slips
                if (frame_tick)
                    state_d = ST_EMIT;
                else if (spe_end)
                    state_d = ST_WAIT;
            end
            default: begin
                state_d = ST_WAIT;
            end
        endcase
    end

    // Free-running timer; store state never delays a wrap
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            frame_cnt_q <= 13'h0000;
        else
            frame_cnt_q <= frame_cnt_d;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            state_q <= ST_WAIT;
        else
            state_q <= state_d;
    end

    // Position restarts at every wrap, even mid-envelope
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos_q   <= 10'h000;
            row_q   <= 4'h0;
            phase_q <= 2'h0;
        end else if (frame_tick) begin
            pos_q   <= 10'h000;
            row_q   <= 4'h0;
            phase_q <= 2'h0;
        end else if (emit) begin
            pos_q   <= pos_d;
            row_q   <= row_d;
            phase_q <= phase_q + 2'h1;
        end
    end

    // Held for a whole envelope; a mid-envelope change would break the rows
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            nopp_q <= OPP_DATA_NOM;
        else if (frame_tick)
            nopp_q <= nopp_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // Store pointers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            wr_q <= 13'h0000;
        else if (wr_en)
            wr_q <= wr_q + 13'h0001;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            rd_q <= 13'h0000;
        else
            rd_q <= rd_d;
    end

    // Bit pairs gather into bytes, first bit in the MSB
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            sh_q <= 6'h00;
        else
            sh_q <= {sh_q[3:0], b0, b1};
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            spe_start <= 1'b0;
        else
            spe_start <= frame_tick;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            spe_byte_valid <= 1'b0;
        else
            spe_byte_valid <= byte_done;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            spe_byte <= 8'h00;
        else if (byte_done)
            spe_byte <= {sh_q, b0, b1};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            opp_data_count <= OPP_DATA_NOM;
        else if (frame_tick)
            opp_data_count <= nopp_d;
    end

    // Overrun drops the bit; the write pointer must not pass the read side
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            store_overrun <= 1'b0;
        else
            store_overrun <= ds3_valid && store_full;
    end

    // Underrun sends zeros and keeps the bits for later positions
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            store_underrun <= 1'b0;
        else
            store_underrun <= starve && (want0 || want1);
    end

endmodule : ds3_sts1_stuffing_mapper

/* File: rtl/stuff_map_pkg.sv */
/*
 * Constants for the DS3 to STS-1 payload envelope stuffing mapper:
 * envelope timing, bit layout of one envelope row, stuffing counts
 * and elastic store sizing.
 * Assumes a 40 MHz system clock; the envelope is emitted two bits a cycle.
 */
package stuff_map_pkg;

    // Envelope period and its cycle count at 40 MHz
    localparam int FRAME_PERIOD_NS = 125000;
    localparam int CLK_PERIOD_NS   = 25;
    localparam int FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;

    // Envelope shape
    localparam logic [3:0] ROWS          = 4'h9;
    localparam logic [9:0] ROW_BITS      = 10'h2B8;  // 696 bits, 87 bytes
    localparam logic [9:0] OH_START      = 10'h008;  // after 8 path overhead bits
    localparam logic [9:0] CTL_START     = 10'h00A;  // 5 stuff control bits
    localparam logic [9:0] OPP_POS       = 10'h00F;  // one opportunity bit a row
    localparam logic [9:0] DATA_START    = 10'h010;  // 621 fixed data bits
    localparam logic [9:0] FIXED_START   = 10'h27D;  // 59 fixed stuff bits

    // Stuffing counts
    localparam int         DS3_BITS_NOM     = 5592;
    localparam int         FIXED_DATA_BITS  = 5589;
    localparam logic [3:0] OPP_DATA_NOM     = 4'h3;
    localparam logic [3:0] OPP_DATA_FAST    = 4'h4;
    localparam logic [3:0] OPP_DATA_SLOW    = 4'h2;

    // Elastic store: depth covers the burst read against a steady write
    localparam int          STORE_AW = 12;
    localparam logic [12:0] STORE_DEPTH = 13'h1000;
    localparam logic [12:0] FILL_HI     = 13'h0A8C;
    localparam logic [12:0] FILL_LO     = 13'h09C4;

    typedef enum logic [2:0] {
        BT_POH   = 3'h0,
        BT_OH    = 3'h1,
        BT_CTL   = 3'h2,
        BT_OPP   = 3'h3,
        BT_DATA  = 3'h4,
        BT_FIXED = 3'h5
    } bit_type_t;

    typedef enum logic [1:0] {
        ST_WAIT = 2'h0,
        ST_EMIT = 2'h1
    } map_state_t;

    function automatic bit_type_t bit_type(input logic [9:0] pos);
        bit_type_t t;
        t = BT_FIXED;
        if (pos < OH_START)
            t = BT_POH;
        else if (pos < CTL_START)
            t = BT_OH;
        else if (pos < OPP_POS)
            t = BT_CTL;
        else if (pos == OPP_POS)
            t = BT_OPP;
        else if (pos < FIXED_START)
            t = BT_DATA;
        return t;
    endfunction : bit_type

endpackage : stuff_map_pkg

/* File: verification/map_checker.sv */
/* Port assertions for the stuffing mapper.
   Bound to every mapper instance; sees its ports only. */
`timescale 1ns/1ps
module map_checker
    import stuff_map_pkg::*;
#(parameter int FRAME_CYC = FRAME_CYCLES) (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       ds3_valid,
    input wire logic       spe_start,
    input wire logic [7:0] spe_byte,
    input wire logic       spe_byte_valid,
    input wire logic [3:0] opp_data_count,
    input wire logic       store_overrun
);
    logic [12:0] cyc_q;
    logic [12:0] idx_q;
    logic        run_q;
    wire  [12:0] col = idx_q % 87;
    wire  [12:0] row = idx_q / 87;
    wire  [4:0]  ctl_exp = (row < opp_data_count) ? 5'h00 : 5'h1F;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {cyc_q, idx_q, run_q} <= '0;
        end else begin
            cyc_q <= spe_start ? 13'h0000 : cyc_q + 13'h0001;
            idx_q <= spe_start ? 13'h0000 : idx_q + {12'h000, spe_byte_valid};
            run_q <= run_q | spe_start;
        end
    end
    ////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_head;
        ##4 (spe_byte_valid && spe_byte == 8'h00);
    endsequence
    AST_PERIOD: assert property (run_q |-> spe_start == (cyc_q == FRAME_CYC - 1))
        else $error("envelope period off");
    AST_HEAD: assert property (spe_start |-> s_head)
        else $error("first byte late or nonzero");
    AST_BYTES: assert property (spe_start && run_q |-> idx_q == 13'h030F)
        else $error("byte count per envelope off");
    AST_GAP: assert property (spe_byte_valid |=> !spe_byte_valid [*3])
        else $error("byte strobes too close");
    AST_CTL: assert property (spe_byte_valid && col == 1 |-> spe_byte[5:1] == ctl_exp)
        else $error("stuff control bits wrong");
    AST_CNT: assert property (opp_data_count inside {4'h2, 4'h3, 4'h4})
        else $error("opportunity count out of range");
    AST_FILL: assert property (spe_byte_valid && (col == 0 || col == 86) |-> spe_byte == 8'h00)
        else $error("fill byte nonzero");
    AST_OVR: assert property (store_overrun |-> $past(ds3_valid))
        else $error("overrun without input");
endmodule : map_checker
bind ds3_sts1_stuffing_mapper map_checker #(.FRAME_CYC(FRAME_CYC)) map_checker_inst (.clk(clk), .nrst(nrst),
    .ds3_valid(ds3_valid), .spe_start(spe_start), .spe_byte(spe_byte), .spe_byte_valid(spe_byte_valid),
    .opp_data_count(opp_data_count), .store_overrun(store_overrun));

/* File: verification/demap_model.sv */
/* Demapper model: walks each envelope bit by bit.
   Needs spe_start before the first byte of an envelope. */
`timescale 1ns/1ps
module demap_model (
    input  wire logic        clk,
    input  wire logic        spe_start,
    input  wire logic [7:0]  spe_byte,
    input  wire logic        spe_byte_valid,
    output logic      [12:0] n_data,
    output logic      [9:0]  n_bytes,
    output logic      [7:0]  first_bits
);
    int pos;
    int ones;
    always @(posedge clk) begin
        if (spe_start) begin
            pos = 0;
            n_data = 13'h0000;
            n_bytes = 10'h000;
        end
        if (spe_byte_valid) begin
            n_bytes = n_bytes + 10'h001;
            for (int i = 7; i >= 0; i--) begin
                if (pos == 10)
                    ones = 0;
                if (pos >= 10 && pos <= 14)
                    ones = ones + spe_byte[i];
                // Majority so up to two corrupted control bits are tolerated
                if ((pos == 15 && ones < 3) || (pos >= 16 && pos <= 636)) begin
                    if (n_data < 8)
                        first_bits[7 - n_data] = spe_byte[i];
                    n_data = n_data + 13'h0001;
                end
                pos = (pos == 695) ? 0 : pos + 1;
            end
        end
    end
endmodule : demap_model

/* File: verification/test_ds3_sts1_stuffing_mapper.sv */
/* Testbench: three store fill levels, one envelope each.
   Mapper and demapper model share the 40 MHz clock. */
`timescale 1ns/1ps
module test_ds3_sts1_stuffing_mapper;
    import stuff_map_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, ds3_bit = 1'b0, ds3_valid = 1'b0, ovr_seen, udr_seen;
    logic spe_start, spe_byte_valid, store_overrun, store_underrun;
    logic [7:0] spe_byte, first_bits;
    logic [3:0] opp_data_count;
    logic [12:0] n_data;
    logic [9:0] n_bytes;
    int n_fail = 0, total_checks = 0;
    ds3_sts1_stuffing_mapper #(.FRAME_CYC(5000)) ds3_sts1_stuffing_mapper_inst (.clk(clk), .nrst(nrst),
        .ds3_bit(ds3_bit), .ds3_valid(ds3_valid), .spe_start(spe_start), .spe_byte(spe_byte),
        .spe_byte_valid(spe_byte_valid), .opp_data_count(opp_data_count), .store_overrun(store_overrun),
        .store_underrun(store_underrun));
    demap_model demap_model_inst (.clk(clk), .spe_start(spe_start), .spe_byte(spe_byte),
        .spe_byte_valid(spe_byte_valid), .n_data(n_data), .n_bytes(n_bytes), .first_bits(first_bits));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        ovr_seen <= nrst & (ovr_seen | store_overrun);
        udr_seen <= nrst & (udr_seen | store_underrun);
    end
    ////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask : chk
    // Fill is preloaded before the first wrap, so it alone picks the stuffing
    task automatic run_env(input int n, input logic [3:0] cnt);
        logic [7:0] ef;
        int k;
        nrst <= 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        for (k = 0; k < n; k++) begin
            @(posedge clk);
            ds3_valid <= 1'b1;
            ds3_bit <= k[0] ^ k[1];
            if (k < 8)
                ef[7 - k] = k[0] ^ k[1];
        end
        @(posedge clk);
        ds3_valid <= 1'b0;
        for (k = 0; k < 6000 && spe_start !== 1'b1; k++) @(negedge clk);
        chk("spe_start", 16'h0001, spe_start);
        chk("opp_data_count", cnt, opp_data_count);
        repeat (3140) @(posedge clk);
        chk("n_data", 16'(FIXED_DATA_BITS + cnt), n_data);
        chk("n_bytes", 16'h030F, n_bytes);
        chk("first_bits", ef, first_bits);
    endtask : run_env
    task automatic t_nominal;
        run_env(2600, OPP_DATA_NOM);
        chk("underrun", 16'h0001, udr_seen);
        $display("test nominal done");
    endtask : t_nominal
    task automatic t_slow;
        run_env(2400, OPP_DATA_SLOW);
        $display("test slow done");
    endtask : t_slow
    task automatic t_fast;
        run_env(4100, OPP_DATA_FAST);
        chk("overrun", 16'h0001, ovr_seen);
        $display("test fast done");
    endtask : t_fast
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report
    initial begin
        t_nominal();
        t_slow();
        t_fast();
        final_report();
    end
    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        final_report();
    end
endmodule : test_ds3_sts1_stuffing_mapper
